// ---- hpm_pkg.sv ----
// Shared constants for the host port pin-function mux and its far-end host
package hpm_pkg;
  localparam int PINS   = 12;
  localparam int BUS_W  = 8;
  localparam int REG_W  = 16;
  localparam int HADR_W = 11;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // Pin order on the shared wire bundle
  localparam int PIN_A0 = 8;   // nonmux_addr_line0 / mux_address_strobe / gpio_bit8
  localparam int PIN_A1 = 9;   // nonmux_addr_line1 / mux_addr_line8 / gpio_bit9
  localparam int PIN_A2 = 10;  // nonmux_addr_line2 / mux_addr_line9 / gpio_bit10
  localparam int PIN_CS = 11;  // nonmux_chip_select / mux_addr_line10 / gpio_bit13
  localparam int GPIO_BIT13_POS = 13;

  // Register offsets
  localparam logic [APB_AW-1:0] OFS_CTRL  = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DIR   = 8'h04;
  localparam logic [APB_AW-1:0] OFS_DOUT  = 8'h08;
  localparam logic [APB_AW-1:0] OFS_DIN   = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_HSTAT = 8'h10;

  // Port control fields
  localparam int CTRL_FUNC_LSB  = 0;
  localparam int CTRL_FUNC_W    = 2;
  localparam int CTRL_MUX_BIT   = 2;
  localparam int CTRL_CSPOL_BIT = 3;
  localparam int CTRL_ASPOL_BIT = 4;
  localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [REG_W-1:0] DIR_RESET  = 16'h0000;
  localparam logic [REG_W-1:0] DOUT_RESET = 16'h0000;
  localparam logic [CTRL_FUNC_W-1:0] FUNC_OFF  = 2'h0;
  localparam logic [CTRL_FUNC_W-1:0] FUNC_GPIO = 2'h1;
  localparam logic [CTRL_FUNC_W-1:0] FUNC_HOST = 2'h2;

  // Host status fields
  localparam int HST_SEL_BIT   = 16;
  localparam int HST_FUNC_LSB  = 24;

  // Host-side phase timing
  localparam int CLK_NS        = 50;
  localparam int HST_PHASE_NS  = 200;
  localparam int HST_PHASE_CYC = (HST_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 4;
endpackage

// ---- hpm_pins_if.sv ----
// Shared host port pin bundle with one modport per end
`timescale 1ns/1ps
interface hpm_pins_if;
  import hpm_pkg::*;
  logic [PINS-1:0] dev_out;
  logic [PINS-1:0] dev_oe;
  logic [PINS-1:0] hst_out;
  logic [PINS-1:0] hst_oe;
  wire  [PINS-1:0] pin;

  // Undriven pins read high, as with a pull-up
  genvar g;
  for (g = 0; g < PINS; g++) begin : g_res
    assign pin[g] = dev_oe[g] ? dev_out[g] : (hst_oe[g] ? hst_out[g] : 1'b1);
  end

  modport dev (output dev_out, output dev_oe, input pin);
  modport hst (output hst_out, output hst_oe, input pin);
endinterface

// ---- hpm_device.sv ----
// Device end: pin-function mux for the 8-bit host port with APB registers
`timescale 1ns/1ps
module hpm_device
  import hpm_pkg::*;
(
  input  wire logic              MCLK,          // Device clock, 20 MHz
  input  wire logic              RST,           // Asynchronous reset, high
  input  wire logic              STOP,          // Stop state request
  input  wire logic              PSEL,          // APB select
  input  wire logic              PENABLE,       // APB access phase
  input  wire logic              PWRITE,        // APB direction
  input  wire logic [APB_AW-1:0] PADDR,         // APB byte address
  input  wire logic [APB_DW-1:0] PWDATA,        // APB write data
  output logic      [APB_DW-1:0] PRDATA,        // APB read data
  output logic                   PREADY,        // APB ready
  output logic                   PSLVERR,       // APB error, unmapped address
  input  wire logic [BUS_W-1:0]  HD_OUT,        // Core data for host reads
  input  wire logic              HD_OE,         // Core wants to drive host bus
  output logic      [BUS_W-1:0]  HOST_DATA_IN,  // Data captured from host
  output logic      [HADR_W-1:0] HOST_ADDR,     // Decoded host address
  output logic                   HOST_SELECT,   // Host access in progress
  hpm_pins_if.dev                hp             // Host port pins
);

  logic [PINS-1:0]   sync1;
  logic [PINS-1:0]   sync2;
  logic [REG_W-1:0]  ctrl;
  logic [REG_W-1:0]  dir;
  logic [REG_W-1:0]  dout;
  logic [PINS-1:0]   gpio_in;
  logic [PINS-1:0]   pin_out;
  logic [PINS-1:0]   pin_oe;
  logic              addr_seen;

  // Configuration decode
  wire [CTRL_FUNC_W-1:0] func     = ctrl[CTRL_FUNC_LSB +: CTRL_FUNC_W];
  wire                   is_gpio  = (func == FUNC_GPIO);
  wire                   is_host  = (func == FUNC_HOST);
  wire                   is_mux   = ctrl[CTRL_MUX_BIT];
  wire                   cs_pol   = ctrl[CTRL_CSPOL_BIT];
  wire                   as_pol   = ctrl[CTRL_ASPOL_BIT];
  wire                   listen   = !STOP && (is_gpio || is_host);

  // GPIO registers packed onto pin order; bit 13 serves the last pin
  wire [PINS-1:0] dir_p  = {dir[GPIO_BIT13_POS], dir[PIN_A2:0]};
  wire [PINS-1:0] dout_p = {dout[GPIO_BIT13_POS], dout[PIN_A2:0]};

  // Host-side strobes, polarity set by control bits (zero = active low)
  wire cs_act = cs_pol ? sync2[PIN_CS] : !sync2[PIN_CS];
  wire as_act = as_pol ? sync2[PIN_A0] : !sync2[PIN_A0];

  wire nm_host  = is_host && !is_mux;
  wire mx_host  = is_host && is_mux;
  wire bus_turn = HD_OE && HOST_SELECT;

  // Address from pins, per bus variant
  wire [HADR_W-1:0] nm_addr = {8'h00, sync2[PIN_A2:PIN_A0]};
  wire [HADR_W-1:0] mx_addr = {sync2[PIN_CS], sync2[PIN_A2], sync2[PIN_A1],
                               sync2[BUS_W-1:0]};

  // Pin drive selection
  wire [PINS-1:0] host_oe  = {{(PINS-BUS_W){1'b0}}, {BUS_W{bus_turn}}};
  wire [PINS-1:0] host_out = {{(PINS-BUS_W){1'b0}}, HD_OUT};
  wire [PINS-1:0] next_pin_oe  = STOP    ? {PINS{1'b0}} :
                                 is_gpio ? dir_p :
                                 is_host ? host_oe : {PINS{1'b0}};
  wire [PINS-1:0] next_pin_out = is_gpio ? dout_p :
                                 is_host ? host_out : {PINS{1'b0}};

  // APB decode
  wire apb_acc = PSEL && PENABLE;
  wire apb_new = apb_acc && !PREADY;
  wire apb_wr  = apb_acc && PREADY && PWRITE;
  wire hit_ctrl  = (PADDR == OFS_CTRL);
  wire hit_dir   = (PADDR == OFS_DIR);
  wire hit_dout  = (PADDR == OFS_DOUT);
  wire hit_din   = (PADDR == OFS_DIN);
  wire hit_hstat = (PADDR == OFS_HSTAT);
  wire hit_any   = hit_ctrl || hit_dir || hit_dout || hit_din || hit_hstat;

  wire [APB_DW-1:0] din_word   = {16'h0000, 2'b00, gpio_in[PIN_CS], 2'b00,
                                  gpio_in[PIN_A2:0]};
  wire [APB_DW-1:0] hstat_word = {6'h00, func, 7'h00, HOST_SELECT, 5'h00, HOST_ADDR};
  wire [APB_DW-1:0] next_prdata;
  assign next_prdata = hit_ctrl  ? {16'h0000, ctrl} :
                       hit_dir   ? {16'h0000, dir} :
                       hit_dout  ? {16'h0000, dout} :
                       hit_din   ? din_word :
                       hit_hstat ? hstat_word : 32'h0000_0000;

  assign hp.dev_out = pin_out;
  assign hp.dev_oe  = pin_oe;

  // Two-flop synchroniser; only sync2 feeds logic
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= hp.pin;
      sync2 <= sync1;
    end
  end

  // Register file; writes land on the edge where PREADY is seen high
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      dir  <= DIR_RESET;
      dout <= DOUT_RESET;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        ctrl <= PWDATA[REG_W-1:0];
      end else if (hit_dir) begin
        dir <= PWDATA[REG_W-1:0];
      end else if (hit_dout) begin
        dout <= PWDATA[REG_W-1:0];
      end
    end
  end

  // APB answer: one wait state, then PREADY for one cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= apb_new;
      PSLVERR <= apb_new && !hit_any;
      if (apb_new) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // Pin drivers, registered
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      pin_oe  <= next_pin_oe;
      pin_out <= next_pin_out;
    end
  end

  // GPIO sampling; output bits read back their own drive
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gpio_in <= '0;
    end else if (listen && is_gpio) begin
      gpio_in <= (sync2 & ~dir_p) | (dout_p & dir_p);
    end
  end

  // Host capture; frozen while stopped, select cleared when unconfigured
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      HOST_ADDR    <= '0;
      HOST_SELECT  <= 1'b0;
      HOST_DATA_IN <= '0;
      addr_seen    <= 1'b0;
    end else if (!listen || !is_host) begin
      if (!STOP) begin
        HOST_SELECT <= 1'b0;
        addr_seen   <= 1'b0;
      end
    end else if (nm_host) begin
      HOST_SELECT <= cs_act;
      addr_seen   <= 1'b0;
      if (cs_act) begin
        HOST_ADDR <= nm_addr;
        // Select lags the pins, so gate on the drive request itself;
        // a host read never overwrites captured write data
        if (!HD_OE) begin
          HOST_DATA_IN <= sync2[BUS_W-1:0];
        end
      end
    end else if (mx_host) begin
      if (as_act) begin
        HOST_ADDR   <= mx_addr;
        addr_seen   <= 1'b1;
        HOST_SELECT <= 1'b0;
      end else begin
        // Data phase follows the strobe; no chip select in this variant
        HOST_SELECT <= addr_seen;
        if (addr_seen && !HD_OE) begin
          HOST_DATA_IN <= sync2[BUS_W-1:0];
        end
      end
    end
  end

endmodule

// ---- hpm_host.sv ----
// Far end: external host bus master driving the host port pins
`timescale 1ns/1ps
module hpm_host
  import hpm_pkg::*;
(
  input  wire logic              MCLK,         // Host logic clock, 20 MHz
  input  wire logic              RST,          // Asynchronous reset, high
  input  wire logic              REQ,          // Start one access, pulse
  input  wire logic              WR,           // Access drives data
  input  wire logic              MUXED,        // Use multiplexed bus variant
  input  wire logic              CS_POL_HIGH,  // Chip select active high
  input  wire logic              AS_POL_HIGH,  // Address strobe active high
  input  wire logic [HADR_W-1:0] ADDR,         // Access address
  input  wire logic [BUS_W-1:0]  WDATA,        // Write data
  input  wire logic              GPIO_MODE,    // Pins driven from EXT_*
  input  wire logic [PINS-1:0]   EXT_OUT,      // Direct pin values
  input  wire logic [PINS-1:0]   EXT_OE,       // Direct pin enables
  output logic                   BUSY,         // Access in progress
  output logic                   DONE,         // Access finished, pulse
  output logic      [BUS_W-1:0]  RDATA,        // Data read from bus
  output logic      [PINS-1:0]   PIN_LEVEL,    // Synchronised pin levels
  hpm_pins_if.hst                hp            // Host port pins
);

  typedef enum {HS_IDLE, HS_ADDR, HS_GAP, HS_DATA, HS_END} hpm_hst_e;

  localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(HST_PHASE_CYC - 1);
  // Read data phase spans two phases: the device turns the bus only after
  // its sync flops, select flop and drive flop, then two flops here
  localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(2 * HST_PHASE_CYC - 1);

  hpm_hst_e          state;
  logic [CNT_W-1:0]  cnt;
  logic [PINS-1:0]   sync1;
  logic [HADR_W-1:0] addr;
  logic [BUS_W-1:0]  wdata;
  logic              wr;
  logic              mux;
  logic [PINS-1:0]   pin_out;
  logic [PINS-1:0]   pin_oe;

  wire cs_on   = CS_POL_HIGH;
  wire as_on   = AS_POL_HIGH;
  wire last    = (cnt == PHASE_LAST);
  wire data_end = wr ? last : (cnt == READ_LAST);
  wire in_addr = (state == HS_ADDR);
  wire in_gap  = (state == HS_GAP);
  wire in_data = (state == HS_DATA);

  // Pin values per phase; strobe and select idle at their inactive level
  wire [BUS_W-1:0] bus_val = (in_addr || in_gap) ? addr[BUS_W-1:0] : wdata;
  wire bus_drv = mux ? (in_addr || in_gap || (in_data && wr)) : (in_data && wr);
  wire a0_val  = mux ? (in_addr ? as_on : !as_on) : addr[0];
  wire [2:0] hi_val = mux ? addr[HADR_W-1:BUS_W]
                          : {(in_data ? cs_on : !cs_on), addr[2:1]};
  wire [PINS-1:0] bus_out = {hi_val, a0_val, bus_val};
  wire [PINS-1:0] bus_oe  = {{(PINS-BUS_W){1'b1}}, {BUS_W{bus_drv}}};

  wire [PINS-1:0] next_pin_out = GPIO_MODE ? EXT_OUT : bus_out;
  wire [PINS-1:0] next_pin_oe  = GPIO_MODE ? EXT_OE  : bus_oe;

  assign hp.hst_out = pin_out;
  assign hp.hst_oe  = pin_oe;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync1     <= '0;
      PIN_LEVEL <= '0;
      pin_out   <= '0;
      pin_oe    <= '0;
    end else begin
      sync1     <= hp.pin;
      PIN_LEVEL <= sync1;
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
    end
  end

  // Access sequencer; each phase lasts HST_PHASE_CYC cycles, a read data phase twice that
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= HS_IDLE;
      cnt   <= '0;
      addr  <= '0;
      wdata <= '0;
      wr    <= 1'b0;
      mux   <= 1'b0;
      BUSY  <= 1'b0;
      DONE  <= 1'b0;
      RDATA <= '0;
    end else begin
      DONE <= 1'b0;
      case (state)
        HS_IDLE: begin
          cnt <= '0;
          if (REQ && !GPIO_MODE) begin
            addr  <= ADDR;
            wdata <= WDATA;
            wr    <= WR;
            mux   <= MUXED;
            BUSY  <= 1'b1;
            state <= MUXED ? HS_ADDR : HS_DATA;
          end
        end
        HS_ADDR: begin
          cnt <= last ? '0 : cnt + 1'b1;
          if (last) begin
            state <= HS_GAP;
          end
        end
        HS_GAP: begin
          cnt <= last ? '0 : cnt + 1'b1;
          if (last) begin
            state <= HS_DATA;
          end
        end
        HS_DATA: begin
          cnt <= data_end ? '0 : cnt + 1'b1;
          if (data_end) begin
            // Sampled level lags the pins by two cycles
            if (!wr) begin
              RDATA <= PIN_LEVEL[BUS_W-1:0];
            end
            state <= HS_END;
          end
        end
        HS_END: begin
          BUSY  <= 1'b0;
          DONE  <= 1'b1;
          state <= HS_IDLE;
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

endmodule

// ---- hpm_props.sv ----
// Concurrent checks on the host port pin bundle
`timescale 1ns/1ps
module hpm_props
  import hpm_pkg::*;
(
  input wire logic             MCLK,        // Device clock
  input wire logic             RST,         // Asynchronous reset, high
  input wire logic             STOP,        // Stop state request
  input wire logic             HD_OE,       // Core drive request
  input wire logic [BUS_W-1:0] HD_OUT,      // Core data for host reads
  input wire logic             HOST_SELECT, // Host access active
  input wire logic [PINS-1:0]  dev_out,     // Device pin values
  input wire logic [PINS-1:0]  dev_oe,      // Device pin enables
  input wire logic [PINS-1:0]  hst_oe       // Host pin enables
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence drive_req_s;
    HOST_SELECT && HD_OE && !STOP;
  endsequence
  // Stop may be registered first, so freeze is judged from the third cycle
  sequence stop_held_s;
    STOP [*3];
  endsequence

  quiet_reset_a:
    assert property ($fell(RST) |-> (dev_oe == '0) [*3]) else $error("pin driven after reset");
  one_driver_a:
    assert property ((dev_oe & hst_oe) == '0) else $error("both ends drive one pin");
  stop_tristate_a:
    assert property (STOP |=> dev_oe == '0) else $error("pin driven in stop");
  stop_freeze_a:
    assert property (stop_held_s |-> $stable(HOST_SELECT)) else $error("select moved in stop");
  bus_enable_a:
    assert property (drive_req_s |=> dev_oe[BUS_W-1:0] == '1) else $error("bus not driven");
  bus_value_a:
    assert property (drive_req_s |=> dev_out[BUS_W-1:0] == $past(HD_OUT))
    else $error("bus carries wrong data");
  bus_release_a:
    assert property ($fell(HD_OE) |=> dev_oe[BUS_W-1:0] == '0) else $error("bus not released");
  select_cause_a:
    assert property ($rose(HOST_SELECT) |-> ($past(hst_oe, 3) & 12'hf00) == 12'hf00)
    else $error("select without host address pins");
endmodule

// ---- tb.sv ----
// Testbench joining the device and host ends of the host port
`timescale 1ns/1ps
module tb;
  import hpm_pkg::*;
  localparam logic [PINS-1:0] DIRS [3] = '{12'hfff, 12'h000, 12'h96c};
  localparam logic [PINS-1:0] DOUTS [3] = '{12'h5a5, 12'h0f0, 12'h3c3};
  localparam logic [PINS-1:0] EXTS [3] = '{12'h000, 12'ha3c, 12'h6b1};
  localparam logic [HADR_W-1:0] MADR [2] = '{11'h7a5, 11'h05a};
  logic              mclk, rst, stop, psel, penable, pwrite, pready, pslverr, err, seen;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [BUS_W-1:0]  hd_out, host_data_in, wdata, rdata;
  logic              hd_oe, host_select, req, wr, muxed, cs_pol, as_pol, gpio_mode, busy, done;
  logic [HADR_W-1:0] host_addr, addr;
  logic [PINS-1:0]   ext_out, ext_oe, pin_level, want;
  int                bad_count, comparisons, i, p;

  hpm_pins_if i_hpm_pins_if ();
  hpm_device i_hpm_device (.MCLK(mclk), .RST(rst), .STOP(stop), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .HD_OUT(hd_out), .HD_OE(hd_oe),
    .HOST_DATA_IN(host_data_in), .HOST_ADDR(host_addr), .HOST_SELECT(host_select),
    .hp(i_hpm_pins_if));
  hpm_host i_hpm_host (.MCLK(mclk), .RST(rst), .REQ(req), .WR(wr), .MUXED(muxed),
    .CS_POL_HIGH(cs_pol), .AS_POL_HIGH(as_pol), .ADDR(addr), .WDATA(wdata),
    .GPIO_MODE(gpio_mode), .EXT_OUT(ext_out), .EXT_OE(ext_oe), .BUSY(busy), .DONE(done),
    .RDATA(rdata), .PIN_LEVEL(pin_level), .hp(i_hpm_pins_if));
  hpm_props i_hpm_props (.MCLK(mclk), .RST(rst), .STOP(stop), .HD_OE(hd_oe),
    .HD_OUT(hd_out), .HOST_SELECT(host_select), .dev_out(i_hpm_pins_if.dev_out),
    .dev_oe(i_hpm_pins_if.dev_oe), .hst_oe(i_hpm_pins_if.hst_oe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    bad_count++;
    $display("unexpected at %0t: %s timed out", $time, what);
    finish_test();
  endtask

  // One APB transfer; waits for PREADY, never assumes its latency
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang("apb");
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // Notes whether the device ever drove the core data onto the bus
  task automatic step();
    @(posedge mclk);
    if (i_hpm_pins_if.dev_oe[7:0] === 8'hff && i_hpm_pins_if.pin[7:0] === hd_out) seen = 1'b1;
  endtask

  // Idle tail lets the select lag die out before the bus changes hands
  task automatic host_acc(input logic w, input logic m, input logic [HADR_W-1:0] a,
                          input logic [BUS_W-1:0] d);
    int n;
    @(posedge mclk);
    req <= 1'b1; wr <= w; muxed <= m; addr <= a; wdata <= d;
    @(posedge mclk);
    req <= 1'b0;
    seen = 1'b0;
    for (n = 0; n < 40 && done !== 1'b1; n++) step();
    if (n >= 40) hang("host access");
    repeat (10) step();
  endtask

  function automatic logic [31:0] to_reg(input logic [PINS-1:0] q);
    return {16'h0, 2'b00, q[PIN_CS], 2'b00, q[PIN_A2:0]};
  endfunction

  initial begin
    rst = 1'b1; stop = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; hd_out = '0; hd_oe = 1'b0; req = 1'b0; wr = 1'b0; muxed = 1'b0;
    cs_pol = 1'b0; as_pol = 1'b0; addr = '0; wdata = '0; gpio_mode = 1'b1;
    ext_out = '0; ext_oe = '0; bad_count = 0; comparisons = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(OFS_CTRL, 32'(CTRL_RESET), "ctrl reset");
    rd_chk(OFS_DIR, 32'(DIR_RESET), "dir reset");
    rd_chk(OFS_DOUT, 32'(DOUT_RESET), "dout reset");
    chk(32'(i_hpm_pins_if.pin), 32'hfff, "pins idle after reset");
    apb(1'b1, OFS_HSTAT, 32'hffff_ffff);
    rd_chk(OFS_HSTAT, 32'h0, "status read only");
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    for (i = 0; i < 3; i++) begin
      ext_oe <= '0;
      apb(1'b1, OFS_CTRL, 32'(FUNC_OFF));
      apb(1'b1, OFS_DIR, to_reg(DIRS[i]));
      apb(1'b1, OFS_DOUT, to_reg(DOUTS[i]));
      apb(1'b1, OFS_CTRL, 32'(FUNC_GPIO));
      ext_out <= EXTS[i];
      ext_oe <= ~DIRS[i];
      repeat (6) @(posedge mclk);
      want = (DIRS[i] & DOUTS[i]) | (~DIRS[i] & EXTS[i]);
      chk(32'(i_hpm_pins_if.pin), 32'(want), "gpio pins");
      chk(32'(pin_level), 32'(want), "host view");
      rd_chk(OFS_DIN, to_reg(want), "gpio input");
    end
    stop <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(i_hpm_pins_if.pin), 32'(DIRS[2] | EXTS[2]), "stop pins");
    stop <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(i_hpm_pins_if.pin), 32'(want), "after stop");
    $display("test gpio done");
    ext_oe <= '0;
    apb(1'b1, OFS_CTRL, 32'(FUNC_OFF));
    gpio_mode <= 1'b0;
    for (p = 0; p < 2; p++) begin
      cs_pol <= p[0];
      apb(1'b1, OFS_CTRL, 32'(FUNC_HOST) | (32'(p) << CTRL_CSPOL_BIT));
      host_acc(1'b1, 1'b0, 11'h005 + 11'(p), 8'hc3 ^ 8'(p));
      chk(32'(host_data_in), 32'(8'hc3 ^ 8'(p)), "nonmux data");
      chk(32'(host_addr[2:0]), 32'(5 + p), "nonmux address");
      hd_out <= 8'h96 ^ 8'(p);
      hd_oe <= 1'b1;
      host_acc(1'b0, 1'b0, 11'h002, 8'h00);
      hd_oe <= 1'b0;
      chk(32'(seen), 32'h1, "device drove bus");
      chk(32'(rdata), 32'(8'h96 ^ 8'(p)), "host read data");
      stop <= 1'b1;
      host_acc(1'b1, 1'b0, 11'h003, 8'h18);
      stop <= 1'b0;
      chk(32'(host_data_in), 32'(8'hc3 ^ 8'(p)), "frozen in stop");
    end
    $display("test nonmux done");
    cs_pol <= 1'b0;
    for (p = 0; p < 2; p++) begin
      as_pol <= p[0];
      apb(1'b1, OFS_CTRL, 32'(FUNC_HOST) | (32'h1 << CTRL_MUX_BIT) | (32'(p) << CTRL_ASPOL_BIT));
      host_acc(1'b1, 1'b1, MADR[p], 8'h69);
      chk(32'(host_addr), 32'(MADR[p]), "mux address");
    end
    $display("test mux done");
    finish_test();
  end
endmodule
